// ===== core/sw_ctrl_pkg.sv
package sw_ctrl_pkg;

  // device address map (word addresses on the device bus)
  localparam logic [13:0] CTRL_ADDR = 14'h0000;
  localparam logic [13:0] FAR_ADDR = 14'h0001;
  localparam int MEM_SEL_BIT = 13;
  localparam int CM_DEPTH = 16;
  localparam int CM_AW = 4;

  // switch_control field positions
  localparam int VALUE_LSB = 13;
  localparam int CLK_SEL_BIT = 11;
  localparam int EVAL_START_BIT = 8;
  localparam int SPARE_BIT = 7;
  localparam int GO_BIT = 6;
  localparam int ARM_BIT = 5;
  localparam int MEM_SELECT_BIT = 4;
  localparam int STANDBY_BIT = 3;
  localparam int RATE_LSB = 0;

  // frame_alignment_result field positions
  localparam int EVAL_SEL_LSB = 11;
  localparam int DONE_BIT = 10;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] FAR_RESET = 16'h0000;
  localparam logic [1:0] PROG_FRAMES = 2'h2;
  localparam int CM_WORD_ZERO_BITS = 13;

  // serial rate modes, one-hot
  typedef enum logic [7:0] {
    RATE_8 = 8'h01,
    RATE_16 = 8'h02,
    RATE_4_8 = 8'h04,
    RATE_16_8 = 8'h08,
    RATE_4 = 8'h10,
    RATE_2_4 = 8'h20,
    RATE_2 = 8'h40,
    RATE_BAD = 8'h80
  } rate_mode_t;

  function automatic rate_mode_t rate_decode(input logic [2:0] sel);
    case (sel)
      3'h0: rate_decode = RATE_8;
      3'h1: rate_decode = RATE_16;
      3'h2: rate_decode = RATE_4_8;
      3'h3: rate_decode = RATE_16_8;
      3'h4: rate_decode = RATE_4;
      3'h5: rate_decode = RATE_2_4;
      3'h6: rate_decode = RATE_2;
      default: rate_decode = RATE_BAD;
    endcase
  endfunction

  // host controller APB map
  localparam logic [7:0] H_CMD = 8'h00;
  localparam logic [7:0] H_WDATA = 8'h04;
  localparam logic [7:0] H_STATUS = 8'h08;
  localparam logic [7:0] H_RDATA = 8'h0C;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_DOUBLE_BIT = 17;

endpackage

// ===== core/sw_bus_if.sv
`timescale 1ns/1ps
interface sw_bus_if;
  logic req;
  logic wr;
  logic [13:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;

  modport dev (
    input req,
    input wr,
    input addr,
    input wdata,
    output rdata,
    output ack
  );

  modport host (
    output req,
    output wr,
    output addr,
    output wdata,
    input rdata,
    input ack
  );
endinterface

// ===== core/switch_control_register.sv
`timescale 1ns/1ps
module switch_control_register (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // processor side
  sw_bus_if.dev bus,
  // frame timing and evaluation datapath
  input wire logic frame_pulse,
  input wire logic eval_valid,
  input wire logic [9:0] eval_delay,
  output logic eval_running,
  output logic [4:0] eval_input_select,
  // data memory fill from the switching core
  input wire logic dm_wr,
  input wire logic [3:0] dm_waddr,
  input wire logic [15:0] dm_wdata,
  // serial output gating
  input wire logic output_drive_pin,
  input wire logic [3:0] channel_enable,
  output logic [3:0] serial_out_stream_oe,
  // mode outputs
  output logic [7:0] rate_mode,
  output logic clock_freq_select,
  output logic slow_clock_allowed,
  output logic block_prog_busy
);

  logic [15:0] ctrl;
  logic [9:0] measured_frame_delay;
  logic frame_eval_done;
  logic [1:0] frame_count;
  logic [15:0] cm [sw_ctrl_pkg::CM_DEPTH];
  logic [15:0] dm [sw_ctrl_pkg::CM_DEPTH];
  logic [15:0] dm_stage;
  logic drive_meta;
  logic drive_sync;
  logic is_mem;
  logic ctrl_wr;
  logic far_wr;
  logic [3:0] idx;
  logic go_rise;
  logic start_rise;
  logic start_fall;
  logic prog_done;
  logic prog_abort;
  logic [15:0] next_ctrl;

  assign is_mem = bus.addr[sw_ctrl_pkg::MEM_SEL_BIT];
  assign idx = bus.addr[sw_ctrl_pkg::CM_AW-1:0];
  assign ctrl_wr = bus.req && bus.wr && !is_mem
                   && bus.addr == sw_ctrl_pkg::CTRL_ADDR;
  assign far_wr = bus.req && bus.wr && !is_mem
                  && bus.addr == sw_ctrl_pkg::FAR_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // control register

  assign go_rise = ctrl_wr && bus.wdata[sw_ctrl_pkg::GO_BIT]
                   && !ctrl[sw_ctrl_pkg::GO_BIT];
  assign start_rise = ctrl_wr && bus.wdata[sw_ctrl_pkg::EVAL_START_BIT]
                      && !ctrl[sw_ctrl_pkg::EVAL_START_BIT];
  assign start_fall = ctrl_wr && !bus.wdata[sw_ctrl_pkg::EVAL_START_BIT]
                      && ctrl[sw_ctrl_pkg::EVAL_START_BIT];
  assign prog_done = block_prog_busy && frame_pulse
                     && frame_count == sw_ctrl_pkg::PROG_FRAMES - 2'h1;
  assign prog_abort = block_prog_busy && ctrl_wr
                      && (!bus.wdata[sw_ctrl_pkg::GO_BIT]
                      || !bus.wdata[sw_ctrl_pkg::ARM_BIT]);

  always_comb
  begin
    next_ctrl = bus.wdata;
    // go only sticks when the feature is armed in the same write
    next_ctrl[sw_ctrl_pkg::GO_BIT] = bus.wdata[sw_ctrl_pkg::GO_BIT]
                                     && bus.wdata[sw_ctrl_pkg::ARM_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      ctrl <= sw_ctrl_pkg::CTRL_RESET;
    else if (ctrl_wr)
      ctrl <= next_ctrl; // a new write wins over the self clear
    else if (prog_done)
      ctrl[sw_ctrl_pkg::GO_BIT] <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // block programming

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      block_prog_busy <= 1'b0;
      frame_count <= 2'h0;
    end
    else if (prog_abort || prog_done)
    begin
      block_prog_busy <= 1'b0;
      frame_count <= 2'h0;
    end
    else if (go_rise && bus.wdata[sw_ctrl_pkg::ARM_BIT])
    begin
      block_prog_busy <= 1'b1;
      frame_count <= 2'h0;
    end
    else if (block_prog_busy && frame_pulse)
      frame_count <= frame_count + 2'h1;
  end

  // whole memory is loaded at once; value taken from the stored register
  always_ff @(posedge clock)
  begin
    if (prog_done)
    begin
      for (int i = 0; i < sw_ctrl_pkg::CM_DEPTH; i++)
        cm[i] <= {ctrl[15:sw_ctrl_pkg::VALUE_LSB],
                  {sw_ctrl_pkg::CM_WORD_ZERO_BITS{1'b0}}};
    end
    else if (bus.req && bus.wr && is_mem)
      cm[idx] <= bus.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame evaluation

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      eval_running <= 1'b0;
    else if (start_rise)
      eval_running <= 1'b1;
    else if (eval_running && eval_valid)
      eval_running <= 1'b0;
    else if (start_fall)
      eval_running <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      frame_eval_done <= 1'b0;
      measured_frame_delay <= 10'h000;
    end
    else if (start_fall)
    begin
      frame_eval_done <= 1'b0;
      measured_frame_delay <= 10'h000;
    end
    else if (eval_running && eval_valid)
    begin
      frame_eval_done <= 1'b1;
      measured_frame_delay <= eval_delay;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      eval_input_select <= sw_ctrl_pkg::FAR_RESET[15:11];
    else if (far_wr)
      eval_input_select <= bus.wdata[15:sw_ctrl_pkg::EVAL_SEL_LSB];
  end

  ////////////////////////////////////////////////////////////////////////////
  // data memory and read path

  always_ff @(posedge clock)
  begin
    if (dm_wr)
      dm[dm_waddr] <= dm_wdata;
  end

  // staging register makes the first data memory read return stale data
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      bus.ack <= 1'b0;
      bus.rdata <= 16'h0000;
      dm_stage <= 16'h0000;
    end
    else
    begin
      bus.ack <= bus.req;
      if (bus.req && !bus.wr)
      begin
        if (is_mem && ctrl[sw_ctrl_pkg::MEM_SELECT_BIT])
        begin
          dm_stage <= dm[idx];
          bus.rdata <= dm_stage;
        end
        else if (is_mem)
          bus.rdata <= cm[idx];
        else if (bus.addr == sw_ctrl_pkg::CTRL_ADDR)
          bus.rdata <= ctrl;
        else if (bus.addr == sw_ctrl_pkg::FAR_ADDR)
          bus.rdata <= {eval_input_select, frame_eval_done,
                        measured_frame_delay};
        else
          bus.rdata <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output gating and modes

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      drive_meta <= 1'b0;
      drive_sync <= 1'b0;
    end
    else
    begin
      drive_meta <= output_drive_pin;
      drive_sync <= drive_meta;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      serial_out_stream_oe <= 4'h0;
    else
      serial_out_stream_oe <= channel_enable
        & {4{ctrl[sw_ctrl_pkg::STANDBY_BIT] | drive_sync}};
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rate_mode <= sw_ctrl_pkg::RATE_8;
      clock_freq_select <= 1'b0;
      slow_clock_allowed <= 1'b0;
    end
    else
    begin
      rate_mode <= sw_ctrl_pkg::rate_decode(ctrl[2:0]);
      clock_freq_select <= ctrl[sw_ctrl_pkg::CLK_SEL_BIT];
      // only the 4 and 2 Mb/s modes may run from the slower clock
      slow_clock_allowed <= ctrl[sw_ctrl_pkg::CLK_SEL_BIT]
        && (ctrl[2:0] == 3'h4 || ctrl[2:0] == 3'h6);
    end
  end

endmodule

// ===== core/switch_control_host.sv
`timescale 1ns/1ps
module switch_control_host (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device side
  sw_bus_if.host bus
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_REQ = 3'h2,
    ST_WAIT = 3'h4
  } host_state_t;

  host_state_t state;
  logic [13:0] cmd_addr;
  logic cmd_write;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] shadow;
  logic reads_left;
  logic pre_clear;
  logic refused;
  logic apb_wr;
  logic launch;
  logic to_ctrl;
  logic [15:0] clean;

  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign to_ctrl = pwdata[13:0] == sw_ctrl_pkg::CTRL_ADDR;
  assign clean = wdata & ~(16'h0001 << sw_ctrl_pkg::SPARE_BIT);
  assign launch = apb_wr && paddr == sw_ctrl_pkg::H_CMD
                  && state == ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      cmd_addr <= 14'h0000;
      cmd_write <= 1'b0;
      reads_left <= 1'b0;
      pre_clear <= 1'b0;
      refused <= 1'b0;
      shadow <= sw_ctrl_pkg::CTRL_RESET;
      rdata <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (launch)
          begin
            cmd_addr <= pwdata[13:0];
            cmd_write <= pwdata[sw_ctrl_pkg::CMD_WRITE_BIT];
            reads_left <= pwdata[sw_ctrl_pkg::CMD_DOUBLE_BIT];
            refused <= 1'b0;
            // while go is held, only go/arm may change
            if (pwdata[sw_ctrl_pkg::CMD_WRITE_BIT] && to_ctrl
                && shadow[sw_ctrl_pkg::GO_BIT] && clean[sw_ctrl_pkg::GO_BIT]
                && ((clean ^ shadow) & 16'hFF9F) != 16'h0000)
              refused <= 1'b1;
            else
            begin
              // a fresh start needs a 0 written first
              // no pre-clear while go is held: it would change bit 8
              pre_clear <= pwdata[sw_ctrl_pkg::CMD_WRITE_BIT] && to_ctrl
                && shadow[sw_ctrl_pkg::EVAL_START_BIT]
                && clean[sw_ctrl_pkg::EVAL_START_BIT]
                && !(shadow[sw_ctrl_pkg::GO_BIT]
                && clean[sw_ctrl_pkg::GO_BIT]);
              state <= ST_REQ;
            end
          end
        ST_REQ:
          state <= ST_WAIT;
        ST_WAIT:
          if (bus.ack)
          begin
            if (pre_clear)
            begin
              pre_clear <= 1'b0;
              shadow[sw_ctrl_pkg::EVAL_START_BIT] <= 1'b0;
              state <= ST_REQ;
            end
            else if (reads_left && !cmd_write)
            begin
              reads_left <= 1'b0; // first value is thrown away
              state <= ST_REQ;
            end
            else
            begin
              if (!cmd_write)
                rdata <= bus.rdata;
              else if (cmd_addr == sw_ctrl_pkg::CTRL_ADDR)
                shadow <= clean;
              state <= ST_IDLE;
            end
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      wdata <= 16'h0000;
    else if (apb_wr && paddr == sw_ctrl_pkg::H_WDATA)
      wdata <= pwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // device bus drive; memory writes only ever reach connection memory

  always_comb
  begin
    bus.req = state == ST_REQ;
    bus.wr = cmd_write;
    bus.addr = cmd_addr;
    // go and value travel in one word
    bus.wdata = pre_clear
      ? (clean & ~(16'h0001 << sw_ctrl_pkg::EVAL_START_BIT)) : clean;
  end

  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      sw_ctrl_pkg::H_CMD: prdata = {14'h0000, reads_left, cmd_write,
                                    2'h0, cmd_addr};
      sw_ctrl_pkg::H_WDATA: prdata = {16'h0000, wdata};
      sw_ctrl_pkg::H_STATUS: prdata = {30'h0, refused, state != ST_IDLE};
      sw_ctrl_pkg::H_RDATA: prdata = {16'h0000, rdata};
      default: prdata = 32'h0000_0000;
    endcase
  end

endmodule

// ===== verif/sw_bus_assertions.sv
`timescale 1ns/1ps
module sw_bus_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // device bus
  input wire logic req,
  input wire logic wr,
  input wire logic [13:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack
);
  logic [15:0] last_ctrl;
  logic ctrl_wr;
  logic ctrl_rd;
  assign ctrl_wr = req && wr && (addr == sw_ctrl_pkg::CTRL_ADDR);
  assign ctrl_rd = req && !wr && (addr == sw_ctrl_pkg::CTRL_ADDR);
  // last control word the host sent, go self-clear not seen
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      last_ctrl <= 16'h0000;
    else if (ctrl_wr)
      last_ctrl <= wdata;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////
  property p_ack_follows;
    req |=> ack && !req;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("ack missing after request");
  property p_ack_cause;
    ack |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_rdata_hold;
    !(req && !wr) |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("rdata moved without read");
  property p_unmapped;
    req && !wr && !addr[13] && addr > 14'h0001 |=> rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_spare_zero;
    ctrl_wr |-> !wdata[sw_ctrl_pkg::SPARE_BIT];
  endproperty
  a_spare_zero: assert property (p_spare_zero)
    else $error("spare control bit written one");
  property p_restart;
    ctrl_wr && wdata[8] |-> !last_ctrl[8];
  endproperty
  a_restart: assert property (p_restart)
    else $error("start set again without clearing");
  property p_go_hold;
    ctrl_wr && last_ctrl[6] && wdata[6]
      |-> ((wdata ^ last_ctrl) & 16'hFF9F) == 16'h0000;
  endproperty
  a_go_hold: assert property (p_go_hold)
    else $error("control changed while go set");
  // go and bits 12, 10 and 9 masked; spare bit compared
  property p_ctrl_back;
    ctrl_rd |=> (rdata & 16'hE9BF) == (last_ctrl & 16'hE9BF);
  endproperty
  a_ctrl_back: assert property (p_ctrl_back)
    else $error("control readback differs");
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [15:0] ctrl;
    logic pin;
    logic [3:0] chen;
    logic [7:0] rate;
    logic slow;
    logic [3:0] oe;
  } row_t;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, rate_mode;
  logic [31:0] pwdata, prdata, rd, st;
  logic frame_pulse, eval_valid, dm_wr, output_drive_pin;
  logic eval_running, clock_freq_select, slow_clock_allowed;
  logic block_prog_busy;
  logic [9:0] eval_delay;
  logic [3:0] dm_waddr, channel_enable, oe;
  logic [15:0] dm_wdata;
  logic [4:0] eval_input_select;
  int error_cnt, checks_done;
  row_t rows [10] = '{
    '{16'h0000, 1'h0, 4'hF, 8'h01, 1'h0, 4'h0},
    '{16'h0009, 1'h0, 4'hA, 8'h02, 1'h0, 4'hA},
    '{16'h0002, 1'h1, 4'h5, 8'h04, 1'h0, 4'h5},
    '{16'h000B, 1'h1, 4'hC, 8'h08, 1'h0, 4'hC},
    '{16'h0804, 1'h0, 4'hF, 8'h10, 1'h1, 4'h0},
    '{16'h0005, 1'h0, 4'h3, 8'h20, 1'h0, 4'h0},
    '{16'h0806, 1'h1, 4'h0, 8'h40, 1'h1, 4'h0},
    '{16'h0006, 1'h0, 4'hF, 8'h40, 1'h0, 4'h0},
    '{16'h080D, 1'h0, 4'h9, 8'h20, 1'h0, 4'h9},
    '{16'h0007, 1'h1, 4'h6, 8'h80, 1'h0, 4'h6}};
  sw_bus_if sw_bus_if_i ();
  switch_control_register switch_control_register_i (
    .clock(clock), .rst_b(rst_b), .bus(sw_bus_if_i.dev),
    .frame_pulse(frame_pulse), .eval_valid(eval_valid),
    .eval_delay(eval_delay), .eval_running(eval_running),
    .eval_input_select(eval_input_select), .dm_wr(dm_wr),
    .dm_waddr(dm_waddr), .dm_wdata(dm_wdata),
    .output_drive_pin(output_drive_pin),
    .channel_enable(channel_enable), .serial_out_stream_oe(oe),
    .rate_mode(rate_mode), .clock_freq_select(clock_freq_select),
    .slow_clock_allowed(slow_clock_allowed),
    .block_prog_busy(block_prog_busy));
  switch_control_host switch_control_host_i (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(sw_bus_if_i.host));
  sw_bus_assertions sw_bus_assertions_i (
    .clock(clock), .rst_b(rst_b), .req(sw_bus_if_i.req),
    .wr(sw_bus_if_i.wr), .addr(sw_bus_if_i.addr),
    .wdata(sw_bus_if_i.wdata), .rdata(sw_bus_if_i.rdata),
    .ack(sw_bus_if_i.ack));
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer, waits for pready however long it takes
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // device access through the host, status left in st
  task automatic dev(input logic w, input logic dbl, input logic [13:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    if (w)
      apb(1'h1, sw_ctrl_pkg::H_WDATA, {16'h0000, d}, q);
    apb(1'h1, sw_ctrl_pkg::H_CMD, {14'h0000, dbl, w, 2'h0, a}, q);
    do apb(1'h0, sw_ctrl_pkg::H_STATUS, 32'h0, st);
    while (st[0] !== 1'h0);
    apb(1'h0, sw_ctrl_pkg::H_RDATA, 32'h0, q);
  endtask
  task automatic frame;
    @(posedge clock);
    frame_pulse <= 1'h1;
    @(posedge clock);
    frame_pulse <= 1'h0;
    @(posedge clock);
  endtask
  task automatic evaluate(input logic [9:0] dly);
    @(posedge clock);
    eval_valid <= 1'h1;
    eval_delay <= dly;
    @(posedge clock);
    eval_valid <= 1'h0;
    @(posedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results;
  end
  initial
  begin
    {rst_b, psel, penable, pwrite, frame_pulse, eval_valid} = 6'h00;
    {dm_wr, output_drive_pin, paddr, pwdata} = 42'h0;
    {eval_delay, dm_waddr, channel_enable, dm_wdata} = 34'h0;
    repeat (4) @(posedge clock);
    rst_b <= 1'h1;
    chk(32'(rate_mode), 32'h01);
    chk(32'(oe), 32'h0);
    chk(32'(pslverr), 32'h0);
    dev(1'h0, 1'h0, sw_ctrl_pkg::FAR_ADDR, 16'h0, rd);
    chk(rd, 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      output_drive_pin <= rows[i].pin;
      channel_enable <= rows[i].chen;
      dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, rows[i].ctrl, rd);
      dev(1'h0, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0, rd);
      chk(rd, {16'h0000, rows[i].ctrl});
      chk(32'(rate_mode), 32'(rows[i].rate));
      chk(32'(slow_clock_allowed), 32'(rows[i].slow));
      chk(32'(clock_freq_select), 32'(rows[i].ctrl[11]));
      chk(32'(oe), 32'(rows[i].oe));
    end
    $display("mode table done");
    // frame evaluation, second result ignored once stopped
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0000, rd);
    dev(1'h1, 1'h0, sw_ctrl_pkg::FAR_ADDR, 16'h9800, rd);
    chk(32'(eval_input_select), 32'h13);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0100, rd);
    chk(32'(eval_running), 32'h1);
    evaluate(10'h2A5);
    chk(32'(eval_running), 32'h0);
    evaluate(10'h011);
    dev(1'h0, 1'h0, sw_ctrl_pkg::FAR_ADDR, 16'h0, rd);
    chk(rd, 32'h9EA5);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0000, rd);
    dev(1'h0, 1'h0, sw_ctrl_pkg::FAR_ADDR, 16'h0, rd);
    chk(rd, 32'h9800);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0100, rd);
    chk(32'(eval_running), 32'h1);
    // start written again while set: host clears it first
    evaluate(10'h011);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0100, rd);
    chk(32'(eval_running), 32'h1);
    dev(1'h0, 1'h0, sw_ctrl_pkg::FAR_ADDR, 16'h0, rd);
    chk(rd, 32'h9800);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0000, rd);
    $display("evaluation test done");
    // block programming over two frames
    dev(1'h1, 1'h0, 14'h2005, 16'h1234, rd);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'hA060, rd);
    chk(32'(block_prog_busy), 32'h1);
    frame;
    chk(32'(block_prog_busy), 32'h1);
    frame;
    chk(32'(block_prog_busy), 32'h0);
    dev(1'h0, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0, rd);
    chk(rd, 32'hA020);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'hA020, rd);
    dev(1'h0, 1'h0, 14'h2005, 16'h0, rd);
    chk(rd, 32'hA000);
    // refused change, then abort by arm and by go
    dev(1'h1, 1'h0, 14'h2005, 16'h1234, rd);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'hC060, rd);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'hC061, rd);
    chk(32'(st[1]), 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'hC060, rd);
      chk(32'(block_prog_busy), 32'h1);
      dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, k ? 16'hC020 : 16'hC040, rd);
      chk(32'(block_prog_busy), 32'h0);
    end
    frame;
    frame;
    dev(1'h0, 1'h0, 14'h2005, 16'h0, rd);
    chk(rd, 32'h1234);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h2040, rd);
    chk(32'(block_prog_busy), 32'h0);
    dev(1'h0, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0, rd);
    chk(rd, 32'h2000);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0000, rd);
    $display("block programming test done");
    // data memory only readable, writes land in connection memory
    @(posedge clock);
    dm_wr <= 1'h1;
    dm_waddr <= 4'h3;
    dm_wdata <= 16'hBEEF;
    @(posedge clock);
    dm_wr <= 1'h0;
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0010, rd);
    dev(1'h0, 1'h1, 14'h2003, 16'h0, rd);
    chk(rd, 32'hBEEF);
    dev(1'h1, 1'h0, 14'h2003, 16'h4321, rd);
    dev(1'h0, 1'h1, 14'h2003, 16'h0, rd);
    chk(rd, 32'hBEEF);
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0000, rd);
    dev(1'h0, 1'h0, 14'h2003, 16'h0, rd);
    chk(rd, 32'h4321);
    dev(1'h1, 1'h0, 14'h0002, 16'hFFFF, rd);
    dev(1'h0, 1'h0, 14'h0002, 16'h0, rd);
    chk(rd, 32'h0);
    $display("memory test done");
    // reset in mid-run with programming pending
    dev(1'h1, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'hA869, rd);
    chk(32'(block_prog_busy), 32'h1);
    rst_b <= 1'h0;
    repeat (2) @(posedge clock);
    rst_b <= 1'h1;
    chk(32'(block_prog_busy), 32'h0);
    chk(32'(rate_mode), 32'h01);
    chk(32'(clock_freq_select), 32'h0);
    chk(32'(oe), 32'h0);
    dev(1'h0, 1'h0, sw_ctrl_pkg::CTRL_ADDR, 16'h0, rd);
    chk(rd, 32'h0);
    $display("mid-run reset test done");
    results;
  end
endmodule
